/* File: rtl/rsm_defines.svh */
// register offsets, field positions, reset values and encodings for the radio state machine config
`ifndef RSM_DEFINES_SVH
`define RSM_DEFINES_SVH
`define RSM_ADDR_CFG1       6'h17
`define RSM_ADDR_CFG0       6'h18
`define RSM_CFG1_RESET      8'h00
`define RSM_CFG0_RESET      8'h04
`define RSM_POSTTX_LSB      0
`define RSM_POSTTX_MSB      1
`define RSM_CAL_LSB         4
`define RSM_CAL_MSB         5
`define RSM_EXP_LSB         2
`define RSM_EXP_MSB         3
`define RSM_CFG1_WMASK      8'h3f
`define RSM_CFG0_WMASK      8'h3f
`define RSM_POSTTX_IDLE     2'h0
`define RSM_POSTTX_SYNTH    2'h1
`define RSM_POSTTX_STAY     2'h2
`define RSM_CAL_NEVER       2'h0
`define RSM_CAL_FROM_IDLE   2'h1
`define RSM_CAL_TO_IDLE     2'h2
`define RSM_CAL_EVERY4      2'h3
`define RSM_EXP_N0          9'h001
`define RSM_EXP_N1          9'h010
`define RSM_EXP_N2          9'h040
`define RSM_EXP_N3          9'h100
`define RSM_RIPPLE_W        6
`define RSM_CAL_CYCLES      8'h10
`endif

/* File: rtl/rsm_pkg.sv */
// types for the radio state machine config block
package rsm_pkg;
  typedef enum logic [3:0] {
    RSM_IDLE  = 4'b0001,
    RSM_CAL   = 4'b0010,
    RSM_SYNTH = 4'b0100,
    RSM_TX    = 4'b1000
  } rsm_state_t;
endpackage : rsm_pkg

/* File: rtl/rsm_powerup.sv */
// power-up expiry counter: ripple counter expiries after the oscillator settles
`timescale 1ns/1ns
`include "rsm_defines.svh"
module rsm_powerup #(
  parameter int RIPPLE_W = `RSM_RIPPLE_W
) (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  // control
  input  wire logic       osc_ok_i,
  input  wire logic [1:0] expiry_sel_i,
  // status
  output logic            chip_ready_n_o,
  output logic            oscillator_settled_o
);
  logic [RIPPLE_W-1:0] rip_q, rip_d;
  logic [8:0]          exp_q, exp_d;
  logic                rdy_q, rdy_d;
  logic [8:0]          target;

  always_comb begin
    unique case (expiry_sel_i)
      2'h0: target = `RSM_EXP_N0;
      2'h1: target = `RSM_EXP_N1;
      2'h2: target = `RSM_EXP_N2;
      default: target = `RSM_EXP_N3;
    endcase
  end

  always_comb begin
    rip_d = rip_q;
    exp_d = exp_q;
    rdy_d = rdy_q;
    if (!osc_ok_i) begin
      // losing the oscillator restarts the whole wait
      rip_d = '0;
      exp_d = '0;
      rdy_d = 1'b0;
    end else if (!rdy_q) begin
      rip_d = rip_q + 1'b1;
      if (&rip_q) begin
        exp_d = exp_q + 9'h001;
        if (exp_q + 9'h001 >= target) rdy_d = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      rip_q <= '0;
      exp_q <= '0;
      rdy_q <= 1'b0;
    end else begin
      rip_q <= rip_d;
      exp_q <= exp_d;
      rdy_q <= rdy_d;
    end
  end

  // both follow one flop so they change together
  assign chip_ready_n_o       = ~rdy_q;
  assign oscillator_settled_o = rdy_q;
endmodule : rsm_powerup

/* File: rtl/rsm_core.sv */
// radio control state machine with its two configuration registers
`timescale 1ns/1ns
`include "rsm_defines.svh"
module rsm_core
  import rsm_pkg::*;
(
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  // register port
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [5:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic [7:0]      reg_rdata_o,
  // command strobes
  input  wire logic       go_tx_i,
  input  wire logic       go_synth_i,
  input  wire logic       go_idle_i,
  input  wire logic       synth_calibrate_strobe_i,
  // radio events
  input  wire logic       packet_done_i,
  input  wire logic       crystal_oscillator_on_i,
  // status
  output logic            cal_busy_o,
  output logic            restart_preamble_o,
  output logic [3:0]      radio_state_o,
  output logic            chip_ready_n_o,
  output logic            oscillator_settled_o
);
  logic [7:0] cfg1_q, cfg1_d;
  logic [7:0] cfg0_q, cfg0_d;
  logic [7:0] rdata_q, rdata_d;
  logic       osc_s1_q, osc_s2_q;
  rsm_state_t st_q, st_d;
  rsm_state_t after_q, after_d;
  logic [7:0] calcnt_q, calcnt_d;
  logic [1:0] ret4_q, ret4_d;
  logic       pre_q, pre_d;
  logic [1:0] after_send_next_state;
  logic [1:0] synth_autocal_select;
  logic       chip_ready_n;

  function automatic logic [7:0] reg_write(input logic [7:0] old, input logic [7:0] wd,
                                           input logic [7:0] mask);
    reg_write = (old & ~mask) | (wd & mask);
  endfunction : reg_write

  assign after_send_next_state = cfg1_q[`RSM_POSTTX_MSB:`RSM_POSTTX_LSB];
  // autocal shares config zero with the expiry setting; config one 5:2 is plain storage
  assign synth_autocal_select  = cfg0_q[`RSM_CAL_MSB:`RSM_CAL_LSB];

  // register file
  always_comb begin
    cfg1_d  = cfg1_q;
    cfg0_d  = cfg0_q;
    rdata_d = rdata_q;
    if (reg_wr_i && reg_addr_i == `RSM_ADDR_CFG1)
      cfg1_d = reg_write(cfg1_q, reg_wdata_i, `RSM_CFG1_WMASK);
    if (reg_wr_i && reg_addr_i == `RSM_ADDR_CFG0)
      cfg0_d = reg_write(cfg0_q, reg_wdata_i, `RSM_CFG0_WMASK);
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `RSM_ADDR_CFG1: rdata_d = cfg1_q;
        `RSM_ADDR_CFG0: rdata_d = cfg0_q;
        default:        rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      cfg1_q  <= `RSM_CFG1_RESET;
      cfg0_q  <= `RSM_CFG0_RESET;
      rdata_q <= 8'h00;
    end else begin
      cfg1_q  <= cfg1_d;
      cfg0_q  <= cfg0_d;
      rdata_q <= rdata_d;
    end
  end

  // oscillator-good comes from the analog side, so synchronise it
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
    end else begin
      osc_s1_q <= crystal_oscillator_on_i;
      osc_s2_q <= osc_s1_q;
    end
  end

  rsm_powerup #(
    .RIPPLE_W (`RSM_RIPPLE_W)
  ) u_powerup (
    .mclk_i               (mclk_i),
    .rst_b_i              (rst_b_i),
    .osc_ok_i             (osc_s2_q),
    .expiry_sel_i         (cfg0_q[`RSM_EXP_MSB:`RSM_EXP_LSB]),
    .chip_ready_n_o       (chip_ready_n),
    .oscillator_settled_o (oscillator_settled_o)
  );

  // radio state machine; in idle no commands are accepted until the chip reports ready, synth and transmit take them regardless
  always_comb begin
    st_d     = st_q;
    after_d  = after_q;
    calcnt_d = calcnt_q;
    ret4_d   = ret4_q;
    pre_d    = 1'b0;
    unique case (st_q)
      RSM_IDLE: begin
        if (!chip_ready_n) begin
          if (synth_calibrate_strobe_i) begin
            st_d     = RSM_CAL;
            after_d  = RSM_IDLE;
            calcnt_d = `RSM_CAL_CYCLES;
          end else if (go_tx_i || go_synth_i) begin
            after_d = go_tx_i ? RSM_TX : RSM_SYNTH;
            if (synth_autocal_select == `RSM_CAL_FROM_IDLE) begin
              st_d     = RSM_CAL;
              calcnt_d = `RSM_CAL_CYCLES;
            end else begin
              st_d = go_tx_i ? RSM_TX : RSM_SYNTH;
            end
          end
        end
      end
      RSM_CAL: begin
        calcnt_d = calcnt_q - 8'h01;
        if (calcnt_q == 8'h01) st_d = after_q;
      end
      RSM_SYNTH: begin
        if (go_tx_i) st_d = RSM_TX;
        else if (go_idle_i) st_d = RSM_IDLE;
      end
      RSM_TX: begin
        if (go_idle_i) begin
          st_d = RSM_IDLE;
        end else if (packet_done_i) begin
          unique case (after_send_next_state)
            `RSM_POSTTX_SYNTH: st_d = RSM_SYNTH;
            `RSM_POSTTX_STAY:  pre_d = 1'b1;
            `RSM_POSTTX_IDLE: begin
              st_d = RSM_IDLE;
              // automatic return to idle: 10 calibrates each time, 11 every fourth
              ret4_d = ret4_q + 2'h1;
              if (synth_autocal_select == `RSM_CAL_TO_IDLE ||
                  (synth_autocal_select == `RSM_CAL_EVERY4 && ret4_q == 2'h3)) begin
                st_d     = RSM_CAL;
                after_d  = RSM_IDLE;
                calcnt_d = `RSM_CAL_CYCLES;
              end
            end
            // reserved code: stay in transmit without restarting
            default: st_d = RSM_TX;
          endcase
        end
      end
      default: st_d = RSM_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      st_q     <= RSM_IDLE;
      after_q  <= RSM_IDLE;
      calcnt_q <= 8'h00;
      ret4_q   <= 2'h0;
      pre_q    <= 1'b0;
    end else begin
      st_q     <= st_d;
      after_q  <= after_d;
      calcnt_q <= calcnt_d;
      ret4_q   <= ret4_d;
      pre_q    <= pre_d;
    end
  end

  assign reg_rdata_o        = rdata_q;
  assign cal_busy_o         = (st_q == RSM_CAL);
  assign restart_preamble_o = pre_q;
  assign radio_state_o      = st_q;
  assign chip_ready_n_o     = chip_ready_n;
endmodule : rsm_core

/* File: bench/rsm_core_props.sv */
// concurrent checks on the ports of the radio state machine config block
`timescale 1ns/1ns
module rsm_core_props (
  // clock, reset and register port
  input wire logic       mclk_i, rst_b_i, reg_wr_i, reg_rd_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i, reg_rdata_o,
  // strobes, events and status
  input wire logic       go_tx_i, go_synth_i, go_idle_i, synth_calibrate_strobe_i,
  input wire logic       packet_done_i, crystal_oscillator_on_i, cal_busy_o,
  input wire logic       restart_preamble_o, chip_ready_n_o, oscillator_settled_o,
  input wire logic [3:0] radio_state_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  ready_pair_a:
    assert property (oscillator_settled_o == !chip_ready_n_o) else $error("settled vs ready");
  top_zero_a:
    assert property (reg_rd_i |=> reg_rdata_o[7:6] == 2'h0) else $error("upper bits set");
  unmapped_rd_a:
    assert property (reg_rd_i && reg_addr_i != 6'h17 && reg_addr_i != 6'h18
      |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  cal_len_a:
    assert property ($rose(cal_busy_o) |-> cal_busy_o [*8]) else $error("calibration short");
  cal_state_a:
    assert property (cal_busy_o == (radio_state_o == 4'h2)) else $error("busy vs state");
  restart_tx_a:
    assert property (restart_preamble_o |-> radio_state_o == 4'h8 && $past(radio_state_o) == 4'h8)
      else $error("restart outside transmit");
  manual_cal_a:
    assert property (radio_state_o == 4'h1 && synth_calibrate_strobe_i && !chip_ready_n_o
      |=> cal_busy_o) else $error("manual calibrate ignored");
  not_ready_a:
    assert property (chip_ready_n_o && radio_state_o == 4'h1 |=> radio_state_o == 4'h1)
      else $error("left idle before ready");
  cover property ($rose(cal_busy_o));
  cover property (restart_preamble_o);
  cover property ($fell(chip_ready_n_o));
endmodule : rsm_core_props

bind rsm_core rsm_core_props i_rsm_core_props (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .go_tx_i(go_tx_i),
  .go_synth_i(go_synth_i), .go_idle_i(go_idle_i),
  .synth_calibrate_strobe_i(synth_calibrate_strobe_i), .packet_done_i(packet_done_i),
  .crystal_oscillator_on_i(crystal_oscillator_on_i), .cal_busy_o(cal_busy_o),
  .restart_preamble_o(restart_preamble_o), .chip_ready_n_o(chip_ready_n_o),
  .oscillator_settled_o(oscillator_settled_o), .radio_state_o(radio_state_o));

/* File: bench/rsm_host_model.sv */
// host model: drives the register port and the command strobes
`timescale 1ns/1ns
module rsm_host_model (
  input  wire logic       mclk_i,
  input  wire logic [7:0] reg_rdata_i,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic [5:0]      reg_addr_o,
  output logic [7:0]      reg_wdata_o,
  output logic [3:0]      cmd_o
);
  initial begin
    reg_wr_o    = 1'h0;
    reg_rd_o    = 1'h0;
    reg_addr_o  = 6'h00;
    reg_wdata_o = 8'h00;
    cmd_o       = 4'h0;
  end
  localparam logic [7:0] PWRUP_CFG = 8'h08;
  task automatic tick;
    @(posedge mclk_i);
    #1;
  endtask : tick
  // released lines are inverted so a stale value never looks valid
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    reg_addr_o = a;
    reg_wdata_o = v;
    reg_wr_o = 1'h1;
    tick;
    reg_wr_o = 1'h0;
    reg_addr_o = ~a;
    reg_wdata_o = ~v;
    tick;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    reg_addr_o = a;
    reg_rd_o = 1'h1;
    tick;
    reg_rd_o = 1'h0;
    reg_addr_o = ~a;
    v = reg_rdata_i;
    tick;
  endtask : rd
  // k: 0 transmit, 1 synth-on, 2 idle, 3 calibrate
  task automatic cmd(input int k);
    cmd_o[k] = 1'h1;
    tick;
    cmd_o = 4'h0;
    tick;
  endtask : cmd
endmodule : rsm_host_model

/* File: bench/rsm_core_test.sv */
// self-checking bench for the radio state machine config block
`timescale 1ns/1ns
module rsm_core_test;
  import rsm_pkg::*;
  logic       mclk_i, rst_b_i, pkt_done, osc_on;
  logic       reg_wr, reg_rd, cal_busy, restart, chip_ready_n, settled;
  logic [3:0] cmd, state;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, rdata, d;
  int         err_count = 0, tests_run = 0, n, i;
  rsm_state_t nx [3] = '{RSM_IDLE, RSM_SYNTH, RSM_TX};
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin err_count++; \
  $display("BAD %s exp %h got %h", nm, e, s); end end
  rsm_core i_rsm_core (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(rdata),
    .go_tx_i(cmd[0]), .go_synth_i(cmd[1]), .go_idle_i(cmd[2]),
    .synth_calibrate_strobe_i(cmd[3]), .packet_done_i(pkt_done),
    .crystal_oscillator_on_i(osc_on), .cal_busy_o(cal_busy), .restart_preamble_o(restart),
    .radio_state_o(state), .chip_ready_n_o(chip_ready_n), .oscillator_settled_o(settled));
  rsm_host_model i_rsm_host_model (.mclk_i(mclk_i), .reg_rdata_i(rdata), .reg_wr_o(reg_wr),
    .reg_rd_o(reg_rd), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .cmd_o(cmd));
  initial begin
    mclk_i = 1'h0;
    forever #25 mclk_i = ~mclk_i;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic wait_st(input logic [3:0] e, output int c);
    c = 0;
    while (state !== e && c < 300) begin
      i_rsm_host_model.tick;
      c++;
    end
    if (state !== e) begin
      err_count++;
      tally_and_finish;
    end
  endtask : wait_st
  task automatic pkt;
    pkt_done = 1'h1;
    i_rsm_host_model.tick;
    pkt_done = 1'h0;
  endtask : pkt
  initial begin
    rst_b_i  = 1'h0;
    pkt_done = 1'h0;
    osc_on   = 1'h0;
    repeat (4) @(posedge mclk_i);
    #1 rst_b_i = 1'h1;
    i_rsm_host_model.rd(6'h17, d); `CHK("cfg one reset", 8'h00, d)
    i_rsm_host_model.rd(6'h18, d); `CHK("cfg zero reset", 8'h04, d)
    i_rsm_host_model.rd(6'h19, d); `CHK("unmapped", 8'h00, d)
    i_rsm_host_model.wr(6'h17, 8'hff);
    i_rsm_host_model.rd(6'h17, d); `CHK("cfg one rw", 8'h3f, d)
    i_rsm_host_model.wr(6'h18, 8'hf3);
    i_rsm_host_model.rd(6'h18, d); `CHK("cfg zero rw", 8'h33, d)
    $display("test registers done");
    // shortest expiry setting keeps the wait to one counter period
    osc_on = 1'h1;
    for (n = 0; chip_ready_n !== 1'h0 && n < 2000; n++) i_rsm_host_model.tick;
    `CHK("powerup window", 1'h1, n >= 64 && n <= 70)
    if (chip_ready_n !== 1'h0) tally_and_finish;
    `CHK("settled", 1'h1, settled)
    $display("test powerup done");
    i_rsm_host_model.wr(6'h17, 8'h00);
    i_rsm_host_model.wr(6'h18, 8'h30);
    for (i = 1; i <= 4; i++) begin
      i_rsm_host_model.cmd(0);
      pkt;
      `CHK("every fourth", i == 4 ? RSM_CAL : RSM_IDLE, state)
      wait_st(RSM_IDLE, n);
    end
    i_rsm_host_model.wr(6'h18, 8'h00);
    i_rsm_host_model.cmd(3); `CHK("manual cal", 1'h1, cal_busy)
    wait_st(RSM_IDLE, n);
    for (i = 0; i < 3; i++) begin
      i_rsm_host_model.wr(6'h17, 8'(i));
      i_rsm_host_model.cmd(0); `CHK("no autocal", RSM_TX, state)
      pkt;
      `CHK("after send", nx[i], state)
      `CHK("restart", i == 2, restart)
      i_rsm_host_model.cmd(2);
      wait_st(RSM_IDLE, n);
    end
    i_rsm_host_model.wr(6'h17, 8'h00);
    i_rsm_host_model.wr(6'h18, 8'h10);
    i_rsm_host_model.cmd(0); `CHK("cal on leave", RSM_CAL, state)
    wait_st(RSM_TX, n); `CHK("cal length", 15, n)
    pkt; `CHK("no cal return", RSM_IDLE, state)
    i_rsm_host_model.cmd(1); `CHK("cal on synth", RSM_CAL, state)
    wait_st(RSM_SYNTH, n); `CHK("synth cal length", 15, n)
    i_rsm_host_model.cmd(0); `CHK("synth to tx", RSM_TX, state)
    i_rsm_host_model.cmd(2);
    wait_st(RSM_IDLE, n);
    i_rsm_host_model.wr(6'h18, 8'h20);
    i_rsm_host_model.cmd(0); `CHK("no cal leave", RSM_TX, state)
    pkt; `CHK("cal on return", RSM_CAL, state)
    wait_st(RSM_IDLE, n);
    i_rsm_host_model.wr(6'h18, i_rsm_host_model.PWRUP_CFG);
    i_rsm_host_model.rd(6'h18, d); `CHK("expiry two", 8'h08, d)
    // losing the oscillator must raise chip-ready again after the two sync flops and the ready flop, three cycles
    osc_on = 1'h0;
    repeat (3) i_rsm_host_model.tick;
    `CHK("osc lost", 1'h1, chip_ready_n)
    `CHK("settled lost", 1'h0, settled)
    $display("test state machine done");
    tally_and_finish;
  end
endmodule : rsm_core_test
